/* verilog/egsm_top.sv */
// Decided for this implementation: the AHB-Lite register port.
`default_nettype none
module egsm_top (
	input  wire logic                 clk,        // 250 MHz clock
	input  wire logic                 rst_b,      // Async reset, low
	input  wire logic                 hsel,       // Slave select
	input  wire logic [31:0]          haddr,      // Byte address
	input  wire logic [1:0]           htrans,     // Transfer type
	input  wire logic                 hwrite,     // Write when high
	input  wire logic [2:0]           hsize,      // Transfer size
	input  wire logic [31:0]          hwdata,     // Write data
	input  wire logic                 hready,     // Bus ready
	input  wire egsm_pkg::egsm_sample_s sample,   // Charge sample
	output logic      [31:0]          hrdata,     // Read data
	output logic                      hreadyout,  // Slave ready
	output logic                      hresp,      // Always OKAY
	output logic                      second_interrupt_pin_out,   // Second pin pulse
	output logic      [7:0]           mach_machine_outputs   // Machine outputs
);
	// ************************************************************
	// State and helpers
	// ************************************************************
	egsm_pkg::egsm_regs_s q; // Registered state
	egsm_pkg::egsm_regs_s d; // Next state
	logic       run_w;        // Program allowed to run
	logic       go_w;         // Executing this cycle
	logic [7:0] op_w;         // Current opcode
	logic [7:0] pp1_w;        // Pointer plus one
	logic [7:0] arg_w;        // Argument byte
	logic       smp_w;        // Sample usable now
	logic       abv_w;        // Scaled sample over limit
	logic [7:0] ti3_w;        // Timer count from header
	// Signed compare of raw*sens against a half float limit
	function automatic logic above_f(input logic signed [15:0] raw,
			input logic [15:0] s, input logic [15:0] t);
		logic signed [63:0] a;
		logic signed [63:0] b;
		logic [4:0]         es;
		logic [4:0]         et;
		// Subnormals use exponent one and no hidden bit
		es = (s[14:10] == 5'h00) ? 5'h01 : s[14:10];
		et = (t[14:10] == 5'h00) ? 5'h01 : t[14:10];
		a = 64'(raw) * $signed({53'h0, (s[14:10] != 5'h00), s[9:0]});
		a = a <<< es;
		b = $signed({53'h0, (t[14:10] != 5'h00), t[9:0]}) <<< et;
		// Sensitivity sign is ignored, limit sign honoured
		if (t[15]) begin
			b = -b;
		end
		return a > b;
	endfunction
	// Both program enable bits must be on
	assign run_w = q.emb_en[egsm_pkg::EN_BIT] & q.pen[egsm_pkg::EN_BIT];
	assign go_w  = run_w & q.run_p & (q.mst == egsm_pkg::ST_RUN);
	assign op_w  = q.mem[q.pp[egsm_pkg::PA_W-1:0]];
	assign pp1_w = q.pp + 8'h01;
	assign arg_w = q.mem[pp1_w[egsm_pkg::PA_W-1:0]];
	// Only the charge channel feeds the external input
	assign smp_w = sample.valid & q.control_seven[egsm_pkg::QEN_BIT] & q.ext;
	assign abv_w = above_f(sample.raw, q.sens,
		{q.mem[egsm_pkg::HDR_THH], q.mem[egsm_pkg::HDR_THL]});
	assign ti3_w = q.mem[egsm_pkg::HDR_TI3];
	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		logic [7:0] rd;
		logic [7:0] wb;
		logic [7:0] tc1;
		logic       rst_hit;
		rd = 8'h00;
		wb = hwdata[7:0];
		tc1 = q.tcnt + 8'h01;
		rst_hit = 1'b0;
		d = q;
		d.irq = 1'b0;
		d.second_interrupt_pin = 1'b0;
		d.hresp = 1'b0;
		d.run_p = run_w;
		// Read mux, bank bit decides the map
		if (q.pix == egsm_pkg::IX_BANK) begin
			rd = q.bank;
		end else if (q.bank[egsm_pkg::BANK_BIT]) begin
			case (q.pix)
				egsm_pkg::IX_PSEL:  rd = q.psel;
				egsm_pkg::IX_EMBEN: rd = q.emb_en;
				egsm_pkg::IX_POFF:  rd = q.poff;
				egsm_pkg::IX_PINT2: rd = q.pint2;
				egsm_pkg::IX_PWE:   rd = q.pwe;
				egsm_pkg::IX_PEN:   rd = q.pen;
				egsm_pkg::IX_5F:    rd = q.rate;
				default:            rd = 8'h00;
			endcase
		end else begin
			case (q.pix)
				egsm_pkg::IX_ACC1:  rd = q.acc1;
				egsm_pkg::IX_GYR2:  rd = q.gyr2;
				egsm_pkg::IX_CONTROL_SEVEN: rd = q.control_seven;
				egsm_pkg::IX_5F:    rd = q.route;
				egsm_pkg::IX_MACHINE_OUTPUTS:  rd = q.machine_outputs;
				egsm_pkg::IX_STAT:  rd = q.pp;
				egsm_pkg::IX_SENSL: rd = q.sens[7:0];
				egsm_pkg::IX_SENSH: rd = q.sens[15:8];
				default:            rd = 8'h00;
			endcase
		end
		// Data phase: one wait cycle so hrdata comes from a flop
		if (q.pend) begin
			d.pend = 1'b0;
			d.hrdy = 1'b1;
			if (!q.pwr) begin
				d.hrdata = {24'h000000, rd};
			end else if (q.pix == egsm_pkg::IX_BANK) begin
				d.bank = wb;
			end else if (q.bank[egsm_pkg::BANK_BIT]) begin
				case (q.pix)
					egsm_pkg::IX_PSEL:  d.psel = wb;
					egsm_pkg::IX_EMBEN: d.emb_en = wb;
					egsm_pkg::IX_POFF:  d.poff = wb;
					egsm_pkg::IX_PINT2: d.pint2 = wb;
					egsm_pkg::IX_PWE:   d.pwe = wb;
					egsm_pkg::IX_PEN:   d.pen = wb;
					egsm_pkg::IX_5F:    d.rate = wb;
					egsm_pkg::IX_PDATA: begin
						// Store and step only while writes are on
						if (q.pwe[egsm_pkg::PWE_BIT]) begin
							if (q.psel[7:4] == egsm_pkg::PAGE_PROG) begin
								d.mem[q.poff[egsm_pkg::PA_W-1:0]] = wb;
							end
							d.poff = q.poff + 8'h01;
						end
					end
					default: d.hresp = 1'b0;
				endcase
			end else begin
				case (q.pix)
					egsm_pkg::IX_ACC1:  d.acc1 = wb;
					egsm_pkg::IX_GYR2:  d.gyr2 = wb;
					egsm_pkg::IX_CONTROL_SEVEN: d.control_seven = wb;
					egsm_pkg::IX_5F:    d.route = wb;
					egsm_pkg::IX_SENSL: d.sens[7:0] = wb;
					egsm_pkg::IX_SENSH: d.sens[15:8] = wb;
					default:            d.hresp = 1'b0;
				endcase
			end
		end
		// Address phase: only whole-word transfers are taken
		if (hsel && htrans[1] && hready && hsize == 3'b010) begin
			d.pend = 1'b1;
			d.hrdy = 1'b0;
			d.pwr = hwrite;
			d.pix = haddr[9:2];
		end
		// Machine: enable edge restarts from the header pointer
		if (!run_w) begin
			d.mst = egsm_pkg::ST_IDLE;
		end else if (!q.run_p) begin
			d.mst = egsm_pkg::ST_RUN;
			d.pp = q.mem[egsm_pkg::HDR_RP];
			d.rp = q.mem[egsm_pkg::HDR_RP];
			d.tcnt = 8'h00;
			d.ext = 1'b0;
		end else if (q.mst == egsm_pkg::ST_RUN) begin
			unique case (op_w)
				egsm_pkg::OP_INSEL: begin
					d.ext = (arg_w == egsm_pkg::ARG_EXT);
					d.pp = q.pp + 8'h02;
				end
				egsm_pkg::OP_MA: begin
					d.amask = 2'd0;
					d.tmask = q.mem[egsm_pkg::HDR_AXIS_MASK_A];
					d.pp = pp1_w;
				end
				egsm_pkg::OP_MB: begin
					d.amask = 2'd1;
					d.tmask = q.mem[egsm_pkg::HDR_AXIS_MASK_B];
					d.pp = pp1_w;
				end
				egsm_pkg::OP_MC: begin
					d.amask = 2'd2;
					d.tmask = q.mem[egsm_pkg::HDR_AXIS_MASK_C];
					d.pp = pp1_w;
				end
				egsm_pkg::OP_SRP: begin
					d.rp = pp1_w;
					d.pp = pp1_w;
				end
				egsm_pkg::OP_CRP: begin
					d.rp = q.mem[egsm_pkg::HDR_RP];
					d.pp = pp1_w;
				end
				egsm_pkg::OP_BLW, egsm_pkg::OP_ABV: begin
					// Stall until a usable sample arrives
					if (smp_w) begin
						rst_hit = (op_w == egsm_pkg::OP_BLW) ? !abv_w : abv_w;
						if (rst_hit) begin
							d.pp = q.rp;
							d.tcnt = 8'h00;
						end else if (tc1 >= ti3_w) begin
							d.pp = pp1_w;
							d.tcnt = 8'h00;
						end else begin
							d.tcnt = tc1;
						end
					end
				end
				egsm_pkg::OP_OUTPUT_CONTINUE_OP: begin
					d.irq = 1'b1;
					d.machine_outputs = q.tmask;
					d.pp = pp1_w;
				end
				egsm_pkg::OP_CREL: begin
					d.irq = 1'b1;
					d.machine_outputs = q.tmask;
					d.pp = q.rp;
				end
				egsm_pkg::OP_STOP: d.mst = egsm_pkg::ST_HALT;
				// Unknown opcodes stop the machine too
				default: d.mst = egsm_pkg::ST_HALT;
			endcase
		end
		// Pin pulse needs both routing bits set
		d.second_interrupt_pin = d.irq & q.pint2[egsm_pkg::EN_BIT] & q.route[egsm_pkg::ROUTE_BIT];
	end
	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= egsm_pkg::REGS_RST;
		end else begin
			q <= d;
		end
	end
	assign hrdata    = q.hrdata;
	assign hreadyout = q.hrdy;
	assign hresp     = q.hresp;
	assign second_interrupt_pin_out  = q.second_interrupt_pin;
	assign mach_machine_outputs = q.machine_outputs;
	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	property p_insel;
		go_w && op_w == egsm_pkg::OP_INSEL && arg_w == egsm_pkg::ARG_EXT
		|=> q.ext && q.pp == $past(q.pp) + 8'h02;
	endproperty
	a_insel: assert property (p_insel) else $error("input select wrong");
	property p_noq;
		go_w && op_w == egsm_pkg::OP_BLW && !q.control_seven[egsm_pkg::QEN_BIT]
		|=> $stable(q.pp) && $stable(q.tcnt);
	endproperty
	a_noq: assert property (p_noq) else $error("sample used while off");
	property p_ma;
		go_w && op_w == egsm_pkg::OP_MA |=> q.amask == 2'd0 && q.pp == $past(pp1_w);
	endproperty
	a_ma: assert property (p_ma) else $error("mask A wrong");
	property p_srp;
		go_w && op_w == egsm_pkg::OP_SRP |=> q.rp == $past(pp1_w) && q.rp == q.pp;
	endproperty
	a_srp: assert property (p_srp) else $error("set pointer wrong");
	property p_blw;
		go_w && op_w == egsm_pkg::OP_BLW && smp_w && !abv_w
		|=> q.pp == $past(q.rp) && q.tcnt == 8'h00;
	endproperty
	a_blw: assert property (p_blw) else $error("low sample no reset");
	property p_abv;
		go_w && op_w == egsm_pkg::OP_ABV && smp_w && abv_w |=> q.pp == $past(q.rp);
	endproperty
	a_abv: assert property (p_abv) else $error("high sample no reset");
	// Timer run: a high sample short of the count only steps the counter
	property p_tmr;
		go_w && op_w == egsm_pkg::OP_BLW && smp_w && abv_w && (q.tcnt + 8'h01) < ti3_w
		|=> q.tcnt == $past(q.tcnt) + 8'h01 && $stable(q.pp);
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer step wrong");
	// Count reached: leave the condition, counter back to zero
	property p_blw_adv;
		go_w && op_w == egsm_pkg::OP_BLW && smp_w && abv_w && (q.tcnt + 8'h01) >= ti3_w
		|=> q.pp == $past(pp1_w) && q.tcnt == 8'h00;
	endproperty
	a_blw_adv: assert property (p_blw_adv) else $error("high run no advance");
	property p_abv_adv;
		go_w && op_w == egsm_pkg::OP_ABV && smp_w && !abv_w && (q.tcnt + 8'h01) >= ti3_w
		|=> q.pp == $past(pp1_w) && q.tcnt == 8'h00;
	endproperty
	a_abv_adv: assert property (p_abv_adv) else $error("low run no advance");
	property p_mb;
		go_w && op_w == egsm_pkg::OP_MB
		|=> q.amask == 2'd1 && q.tmask == $past(q.mem[egsm_pkg::HDR_AXIS_MASK_B]);
	endproperty
	a_mb: assert property (p_mb) else $error("mask B wrong");
	property p_output_continue_op;
		go_w && op_w == egsm_pkg::OP_OUTPUT_CONTINUE_OP
		|=> q.irq && q.machine_outputs == $past(q.tmask) && q.pp == $past(pp1_w);
	endproperty
	a_output_continue_op: assert property (p_output_continue_op) else $error("output continue wrong");
	// Outputs move only together with an output instruction's event
	property p_machine_outputs;
		!q.irq |-> $stable(q.machine_outputs);
	endproperty
	a_machine_outputs: assert property (p_machine_outputs) else $error("outputs moved");
	property p_crp;
		go_w && op_w == egsm_pkg::OP_CRP |=> q.rp == $past(q.mem[egsm_pkg::HDR_RP]);
	endproperty
	a_crp: assert property (p_crp) else $error("clear pointer wrong");
	property p_mc;
		go_w && op_w == egsm_pkg::OP_MC |=> q.amask == 2'd2 && q.pp == $past(pp1_w);
	endproperty
	a_mc: assert property (p_mc) else $error("mask C wrong");
	property p_crel;
		go_w && op_w == egsm_pkg::OP_CREL |=> q.irq && q.pp == $past(q.rp);
	endproperty
	a_crel: assert property (p_crel) else $error("release wrong");
	property p_stop;
		go_w && op_w == egsm_pkg::OP_STOP |=> q.mst == egsm_pkg::ST_HALT;
	endproperty
	a_stop: assert property (p_stop) else $error("stop not taken");
	property p_page;
		q.pend && q.pwr && q.bank[egsm_pkg::BANK_BIT] && q.pix == egsm_pkg::IX_PDATA
		&& q.pwe[egsm_pkg::PWE_BIT] |=> q.poff == $past(q.poff) + 8'h01;
	endproperty
	a_page: assert property (p_page) else $error("offset not stepped");
	property p_nowe;
		q.pend && q.pwr && q.pix == egsm_pkg::IX_PDATA && !q.pwe[egsm_pkg::PWE_BIT]
		|=> $stable(q.poff) && $stable(q.mem);
	endproperty
	a_nowe: assert property (p_nowe) else $error("page write leaked");
	// Pin pulse is the event gated by both routing bits as they stood;
	// back to back events may legally give a two cycle pulse
	property p_second_interrupt_pin;
		q.second_interrupt_pin == (q.irq && $past(q.pint2[egsm_pkg::EN_BIT])
			&& $past(q.route[egsm_pkg::ROUTE_BIT]));
	endproperty
	a_second_interrupt_pin: assert property (p_second_interrupt_pin) else $error("pin pulse wrong");
	property p_start;
		run_w && !q.run_p |=> q.pp == $past(q.mem[egsm_pkg::HDR_RP]) && q.tcnt == 8'h00
		&& q.mst == egsm_pkg::ST_RUN;
	endproperty
	a_start: assert property (p_start) else $error("start not clean");
	property p_bus;
		q.pend |-> !q.hrdy ##1 q.hrdy;
	endproperty
	a_bus: assert property (p_bus) else $error("bus wait wrong");
	// ************************************************************
	// Coverage of the main scenarios
	// ************************************************************
	c_output_continue_op: cover property (go_w && op_w == egsm_pkg::OP_OUTPUT_CONTINUE_OP);
	c_crel: cover property (go_w && op_w == egsm_pkg::OP_CREL);
	c_tmr:  cover property (go_w && op_w == egsm_pkg::OP_BLW && smp_w && abv_w
		&& (q.tcnt + 8'h01) == ti3_w);
	c_brk:  cover property (go_w && op_w == egsm_pkg::OP_BLW && smp_w && !abv_w
		&& q.tcnt != 8'h00);
	c_pin:  cover property (q.second_interrupt_pin);
endmodule
`default_nettype wire

/* verilog/egsm_pkg.sv */
`default_nettype none
package egsm_pkg;
	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [7:0] IX_BANK  = 8'h01; // Bank switch, both banks
	localparam logic [7:0] IX_PSEL  = 8'h02; // Page select
	localparam logic [7:0] IX_EMBEN = 8'h05; // Function enable
	localparam logic [7:0] IX_POFF  = 8'h08; // Page offset
	localparam logic [7:0] IX_PDATA = 8'h09; // Page data
	localparam logic [7:0] IX_PINT2 = 8'h0F; // Program to second pin
	localparam logic [7:0] IX_ACC1  = 8'h10; // Accel control one
	localparam logic [7:0] IX_GYR2  = 8'h11; // Gyro control two
	localparam logic [7:0] IX_CONTROL_SEVEN = 8'h16; // Control seven
	localparam logic [7:0] IX_PWE   = 8'h17; // Page write enable
	localparam logic [7:0] IX_PEN   = 8'h46; // Program enable
	localparam logic [7:0] IX_5F    = 8'h5F; // Rate or routing
	localparam logic [7:0] IX_MACHINE_OUTPUTS  = 8'h70; // Machine outputs
	localparam logic [7:0] IX_STAT  = 8'h71; // Program pointer
	localparam logic [7:0] IX_SENSL = 8'h72; // Sensitivity low
	localparam logic [7:0] IX_SENSH = 8'h73; // Sensitivity high
	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int          BANK_BIT  = 7;         // Embedded bank on
	localparam int          PWE_BIT   = 6;         // Page writes on
	localparam int          QEN_BIT   = 7;         // Charge channel on
	localparam int          ROUTE_BIT = 1;         // Main bank routing
	localparam int          EN_BIT    = 0;         // Generic enable
	localparam logic [3:0]  PAGE_PROG = 4'h4;      // Program page
	localparam logic [15:0] SENS_RST  = 16'h1624;  // Half float 0.0015
	// ************************************************************
	// Program header offsets
	// ************************************************************
	localparam logic [7:0] HDR_RP    = 8'h04; // Reset pointer
	localparam logic [7:0] HDR_THL   = 8'h06; // Limit low byte
	localparam logic [7:0] HDR_THH   = 8'h07; // Limit high byte
	localparam logic [7:0] HDR_AXIS_MASK_A = 8'h08; // Mask A
	localparam logic [7:0] HDR_AXIS_MASK_B = 8'h0A; // Mask B
	localparam logic [7:0] HDR_AXIS_MASK_C = 8'h0C; // Mask C
	localparam logic [7:0] HDR_TI3   = 8'h0F; // Third timer count
	// ************************************************************
	// Opcodes
	// ************************************************************
	localparam logic [7:0] OP_STOP  = 8'h00;
	localparam logic [7:0] OP_INSEL = 8'h23;
	localparam logic [7:0] ARG_EXT  = 8'h02;
	localparam logic [7:0] OP_MA    = 8'h66;
	localparam logic [7:0] OP_MB    = 8'h77;
	localparam logic [7:0] OP_MC    = 8'h88;
	localparam logic [7:0] OP_SRP   = 8'h33;
	localparam logic [7:0] OP_CRP   = 8'h44;
	localparam logic [7:0] OP_BLW   = 8'h73;
	localparam logic [7:0] OP_ABV   = 8'h53;
	localparam logic [7:0] OP_OUTPUT_CONTINUE_OP  = 8'h99;
	localparam logic [7:0] OP_CREL  = 8'h22;
	localparam int         PROG_BYTES = 64; // Program page depth
	localparam int         PA_W       = 6;  // Program address width
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_HALT = 2'b11
	} egsm_state_e;
	typedef struct packed {
		logic               valid; // Sample strobe
		logic signed [15:0] raw;   // Raw charge sample
	} egsm_sample_s;
	typedef struct packed {
		logic [PROG_BYTES-1:0][7:0] mem;
		logic [15:0] sens;
		logic [7:0]  bank, psel, emb_en, poff, pint2, acc1, gyr2;
		logic [7:0]  control_seven, pwe, pen, rate, route;
		logic [31:0] hrdata;
		logic        hrdy, hresp, pend, pwr;
		logic [7:0]  pix;
		egsm_state_e mst;
		logic [7:0]  pp, rp, tcnt, tmask, machine_outputs;
		logic [1:0]  amask;
		logic        ext, run_p, irq, second_interrupt_pin;
	} egsm_regs_s;
	localparam egsm_regs_s REGS_RST = '{hrdy: 1'b1, sens: SENS_RST,
		mst: ST_IDLE, default: '0};
endpackage
`default_nettype wire

/* verilog/egsm_fix.sv */
`default_nettype none
`default_nettype wire

/* verification/egsm_src_model.sv */
`default_nettype none
// ************************************************************
// Charge sample source on the far side of the sample port
// ************************************************************
module egsm_src_model #(
	parameter int GAP = 6 // Idle cycles between samples
) (
	input  wire logic                   clk,    // Bench clock
	input  wire logic                   rst_b,  // Async reset, low
	input  wire logic                   go,     // Load a new burst
	input  wire logic [7:0]             cnt,    // Samples in burst
	input  wire logic [15:0]            val,    // Raw value to send
	output egsm_pkg::egsm_sample_s      sample, // Sample to the machine
	output logic                        idle    // Burst finished
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  left_q; // Samples still to send
	logic [3:0]  tick_q; // Gap counter
	logic [15:0] last_q; // Last value put on the lines
	// Burst engine; between strobes the raw lines carry the inverse
	// of the last value, so a stale value never looks valid
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			left_q <= 8'h00;
			tick_q <= 4'h0;
			last_q <= 16'h0000;
			sample <= '0;
		end else begin
			sample.valid <= 1'b0;
			sample.raw   <= ~last_q;
			if (go) begin
				left_q <= cnt;
				tick_q <= 4'(GAP);
			end else if (left_q != 8'h00) begin
				// Gap keeps the machine's non-sample steps out of the way
				if (tick_q == 4'h0) begin
					sample.valid <= 1'b1;
					sample.raw   <= val;
					last_q       <= val;
					left_q       <= left_q - 8'h01;
					tick_q       <= 4'(GAP);
				end else begin
					tick_q <= tick_q - 4'h1;
				end
			end
		end
	end
	assign idle = (left_q == 8'h00) && !go;
endmodule
`default_nettype wire

/* verification/embedded_gesture_state_machine_test.sv */
`default_nettype none
module embedded_gesture_state_machine_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Signals
	// ************************************************************
	logic                   clk, rst_b, hsel, hwrite, hreadyout, hresp, second_interrupt_pin_out;
	logic [31:0]            haddr, hwdata, hrdata;
	logic [1:0]             htrans;
	logic [2:0]             hsize;
	logic [7:0]             mach_machine_outputs, src_cnt;
	logic [15:0]            src_val;
	logic                   src_go, src_idle;
	egsm_pkg::egsm_sample_s sample;
	int                     errors, total_checks, pulses;
	// Host script: {index, data}; a refused page write sits before
	// the image so a wrong offset step would shift the program
	localparam logic [15:0] CFG_A [21] = '{16'h1000, 16'h1100, 16'h0180, 16'h0501,
		16'h5F4B, 16'h4601, 16'h0F01, 16'h1740, 16'h0211, 16'h087A, 16'h0900,
		16'h0900, 16'h0901, 16'h0901, 16'h0900, 16'h0904, 16'h0241, 16'h0800,
		16'h1700, 16'h09FF, 16'h1740};
	localparam logic [7:0] IMG [30] = '{8'h71, 8'h00, 8'h1E, 8'h00, 8'h10, 8'h00,
		8'h00, 8'h52, 8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0A,
		8'h23, 8'h02, 8'h66, 8'h33, 8'h73, 8'h77, 8'h99, 8'h66, 8'h33, 8'h53,
		8'h44, 8'h88, 8'h22, 8'h00};
	// Enable toggled after loading: the early start halted on empty memory
	localparam logic [15:0] CFG_B [7] = '{16'h0201, 16'h1700, 16'h4600, 16'h4601,
		16'h0100, 16'h5F02, 16'h1074};
	// ************************************************************
	// Design and sample source
	// ************************************************************
	egsm_top i_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .sample(sample), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .second_interrupt_pin_out(second_interrupt_pin_out),
		.mach_machine_outputs(mach_machine_outputs));
	egsm_src_model #(.GAP(6)) i_src (.clk(clk), .rst_b(rst_b), .go(src_go),
		.cnt(src_cnt), .val(src_val), .sample(sample), .idle(src_idle));
	// Clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Pin pulses counted where the register output is settled
	always @(negedge clk) begin
		if (second_interrupt_pin_out === 1'b1) pulses++;
	end
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic give_verdict();
		if (errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t %s seen %h want %h", $time, msg, seen, exp);
		end
	endtask
	// One single word transfer; entered just after a rising edge.
	// Ready is looked at on the falling edge, where it already holds
	// the value the next rising edge samples.
	task automatic bus(input logic [7:0] ix, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd);
		haddr  <= {22'h000000, ix, 2'b00};
		htrans <= 2'b10;
		hwrite <= wr;
		@(negedge clk);
		while (hreadyout !== 1'b1) @(negedge clk);
		@(posedge clk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(negedge clk);
		while (hreadyout !== 1'b1) @(negedge clk);
		rd = hrdata;
		@(posedge clk);
		// Only the watchdog ends a wait; every transfer must answer OKAY
		check({31'h00000000, hresp}, 32'h00000000, "bus response");
	endtask
	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		logic [31:0] x;
		bus(ix, 1'b1, {24'h000000, d}, x);
	endtask
	task automatic rdc(input logic [7:0] ix, input logic [7:0] exp, input string msg);
		logic [31:0] x;
		bus(ix, 1'b0, 32'h00000000, x);
		check(x, {24'h000000, exp}, msg);
		check({31'h00000000, hresp}, 32'h00000000, "hresp");
	endtask
	// A burst of n equal samples, then settle
	task automatic feed(input logic [15:0] v, input logic [7:0] n);
		int k;
		k = 0;
		src_val <= v;
		src_cnt <= n;
		src_go  <= 1'b1;
		@(posedge clk);
		src_go <= 1'b0;
		@(negedge clk);
		while (src_idle !== 1'b1 && k < 4000) begin k++; @(negedge clk); end
		repeat (8) @(posedge clk);
		if (k >= 4000) check(32'h1, 32'h0, "source stuck");
	endtask
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		errors = 0; total_checks = 0; pulses = 0;
		rst_b = 1'b0; hsel = 1'b1; hwrite = 1'b0; hsize = 3'b010;
		haddr = 32'h00000000; hwdata = 32'h00000000; htrans = 2'b00;
		src_go = 1'b0; src_cnt = 8'h00; src_val = 16'h0000;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rdc(8'h72, 8'h24, "sens low");
		rdc(8'h73, 8'h16, "sens high");
		foreach (CFG_A[i]) wr(CFG_A[i][15:8], CFG_A[i][7:0]);
		foreach (IMG[i]) wr(8'h09, IMG[i]);
		rdc(8'h08, 8'h1E, "offset");
		rdc(8'h09, 8'h00, "page data");
		rdc(8'h5F, 8'h4B, "rate");
		foreach (CFG_B[i]) wr(CFG_B[i][15:8], CFG_B[i][7:0]);
		rdc(8'h5F, 8'h02, "routing");
		rdc(8'h10, 8'h74, "accel");
		rdc(8'h3F, 8'h00, "unmapped");
		rdc(8'h71, 8'h14, "start ptr");
		// Channel off: conditions must stall
		feed(16'h7FFF, 8'h0C);
		rdc(8'h71, 8'h14, "ptr no channel");
		wr(8'h16, 8'hB0);
		// Break in the run of high samples restarts the count
		feed(16'h7FFF, 8'h09);
		feed(16'h7D00, 8'h01);
		feed(16'h7FFF, 8'h09);
		check({24'h000000, mach_machine_outputs}, 32'h00, "machine_outputs early");
		check(pulses, 0, "pulse early");
		feed(16'h7FFF, 8'h01);
		check({24'h000000, mach_machine_outputs}, 32'h01, "machine_outputs in");
		check(pulses, 1, "pulse in");
		rdc(8'h71, 8'h19, "ptr wait low");
		// Negative full scale counts as low; one high sample restarts
		feed(16'h8000, 8'h09);
		feed(16'h7FFF, 8'h01);
		feed(16'h8000, 8'h09);
		check(pulses, 1, "pulse early out");
		feed(16'h8000, 8'h01);
		check({24'h000000, mach_machine_outputs}, 32'h00, "machine_outputs out");
		check(pulses, 2, "pulse out");
		rdc(8'h71, 8'h14, "ptr back");
		// Routing off: outputs move, pin stays quiet
		wr(8'h5F, 8'h00);
		feed(16'h7FFF, 8'h0A);
		check({24'h000000, mach_machine_outputs}, 32'h01, "machine_outputs unrouted");
		check(pulses, 2, "pulse unrouted");
		wr(8'h70, 8'hFF);
		rdc(8'h70, 8'h01, "machine_outputs read only");
		give_verdict();
	end
	// Watchdog, well beyond the under one thousand cycles the tests need
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		$display("BAD %0t watchdog", $time);
		give_verdict();
	end
endmodule
`default_nettype wire
